// *** src/dbgk_core.sv ***
// debug port key handling, information block readout and load streaming
//
// Operation
// [RL1] repeated load: guard only before first byte
// [RL2] programmer uses post-increment, instruction once
// [RL3] direct access repeats send address each time
// [RL4] key only 64 bits, block at most 128
// [RL5] frame count sets key or block bytes
// [RL6] no answer to key; block uses guard
// [RL7] boot checksum result readable when locked
// [RL8] delay bit adds two idle bits between bytes
// [RL9] no guard between same-direction bytes
// [RL10] information block readable regardless of lock
// [RL11] sixteen bytes full block, eight family only
// [RL12] fixed byte layout of information block
// [RL13] three keys with own invalidation conditions
// [RL14] exact 64-bit signature match activates key
// [RL15] valid erase key sets erase status bit
// [RL16] reset signature holds reset until zero
// [RL17] programmer erase sequence ends polling lock
// [RL18] erase success clears erase-failed bit
// [RL19] locked port refuses system bus access
// [RL20] repeated instruction runs count plus one
// [RL21] shift in eight bytes, compare after last
// [RL22] delay enable resets to zero
//
// Design decisions made here: the register offsets and the APB slave port.
`include "dbgk_params.svh"
`default_nettype none
module dbgk_core
  import dbgk_pkg::*;
#(
  parameter int SIB_BYTES = 16,
  parameter logic [55:0] FAMILY_IDENTIFIER = 56'h4641_4D49_4C59_20, // arbitrary value
  parameter logic [23:0] MEM_CTRL_REV = 24'h5030_31, // arbitrary value
  parameter logic [23:0] DEBUGGER_REV = 24'h4430_31, // arbitrary value
  parameter logic [7:0] DEBUG_OSC_FREQ = 8'h33 // arbitrary value
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // decoded instructions from the link layer
  input wire logic key_start,
  input wire logic key_sib_mode,
  input wire logic [4:0] key_frames,
  input wire logic ld_start,
  input wire logic [2:0] ld_size,
  input wire logic [7:0] rpt_count,
  input wire logic link_break,
  // received bytes
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  // load data from the access layer
  input wire logic ld_valid,
  input wire logic [7:0] ld_data,
  output logic ld_ready,
  // bytes to the physical layer
  input wire logic tx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_guard,
  output logic [1:0] tx_idle_bits,
  output logic [2:0] guard_time,
  // system side
  input wire logic lock_bits,
  input wire logic port_disable,
  input wire logic erase_done,
  input wire logic erase_fail,
  input wire logic nvm_prog_done,
  input wire logic urow_complete,
  input wire logic [7:0] boot_checksum_result,
  output logic sys_reset,
  output logic erase_start,
  output logic nvm_prog_enable,
  output logic urow_done,
  output logic sys_bus_allow
);
  localparam logic [127:0] SIB_CONTENT = {
    DEBUG_OSC_FREQ, `DBGK_RESERVED_BYTE, DEBUGGER_REV, MEM_CTRL_REV,
    `DBGK_RESERVED_BYTE, FAMILY_IDENTIFIER
  }; // [RL12]

  if (SIB_BYTES != 16) begin : g_check
    $error("information block must be sixteen bytes");
  end

  // index of a word-aligned register address
  function automatic logic [3:0] reg_idx(input logic [11:0] a);
    reg_idx = a[5:2];
  endfunction : reg_idx

  // true for a mapped, aligned register address
  function automatic logic reg_ok(input logic [11:0] a);
    logic [3:0] i;
    i = a[5:2];
    reg_ok = (a[11:6] == 6'h00) && (a[1:0] == 2'b00) &&
      (i == `DBGK_IDX_CTRLA || i == `DBGK_IDX_UNLOCK_STATUS ||
       i == `DBGK_IDX_RESET_REQUEST || i == `DBGK_IDX_SYS_CTRLA ||
       i == `DBGK_IDX_SYS_STATUS || i == `DBGK_IDX_BOOT_CHECKSUM);
  endfunction : reg_ok

  // stream state
  dbgk_state_t st_q, st_d;
  logic [10:0] cnt_q, cnt_d;
  logic [63:0] key_q, key_d;
  logic [3:0] idx_q, idx_d;
  logic first_q, first_d;
  logic txv_q, txv_d;
  logic [7:0] txd_q, txd_d;
  logic txg_q, txg_d;
  logic [1:0] txi_q, txi_d;
  logic ldr_q, ldr_d;
  logic key_done;
  logic [7:0] rom_data;
  // register state
  logic inter_byte_delay_enable_q, inter_byte_delay_enable_d;
  logic [2:0] gt_q, gt_d;
  logic [7:0] reset_request_code_q, reset_request_code_d;
  logic sysres_q, sysres_d;
  logic ke_q, ke_d, kn_q, kn_d, ku_q, ku_d;
  logic mp_q, mp_d, up_q, up_d;
  logic efail_q, efail_d;
  logic estart_q, estart_d;
  logic udone_q, udone_d;
  logic allow_q;
  // bus state
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;
  logic acc, wr, rel;
  logic [3:0] widx;

  dbgk_sib_rom #(
    .BYTES(SIB_BYTES),
    .CONTENT(SIB_CONTENT)
  ) u_rom (
    .pclk(pclk),
    .presetn(presetn),
    .addr(idx_q),
    .rd_data(rom_data)
  );

  // stream sequencer: key intake, block readout and load forwarding
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    key_d = key_q;
    idx_d = idx_q;
    first_d = first_q;
    txv_d = txv_q;
    txd_d = txd_q;
    txg_d = txg_q;
    txi_d = txi_q;
    key_done = 1'b0;
    if (txv_q && tx_ready) begin
      txv_d = 1'b0;
    end
    case (st_q)
      DBGK_S_IDLE: begin
        if (key_start) begin
          if (key_sib_mode) begin
            // readout allowed whatever the lock state
            idx_d = 4'h0; // [RL10]
            first_d = 1'b1;
            cnt_d = (key_frames > `DBGK_SIB_BYTES) ? 11'(`DBGK_SIB_BYTES)
                                                   : 11'(key_frames); // [RL4] [RL5] [RL11]
            if (key_frames != 5'h00) begin
              st_d = DBGK_S_SIB_WAIT;
            end
          end else if (key_frames == `DBGK_KEY_BYTES) begin // [RL4]
            cnt_d = 11'(`DBGK_KEY_BYTES); // [RL5]
            st_d = DBGK_S_KEY_RX;
          end
        end else if (ld_start && !lock_bits && ld_size != 3'h0) begin // [RL19]
          // widen before the product so 256 blocks of four bytes still fit
          cnt_d = (11'(rpt_count) + 11'h001) * 11'(ld_size); // [RL20]
          first_d = 1'b1;
          st_d = DBGK_S_LD_RUN;
        end
      end
      DBGK_S_KEY_RX: begin
        // key bytes shift in from the top, no answer goes back
        if (rx_valid) begin
          key_d = {rx_data, key_q[63:8]}; // [RL14] [RL21] [RL6]
          cnt_d = cnt_q - 11'h001;
          if (cnt_q == 11'h001) begin
            key_done = 1'b1; // [RL21]
            st_d = DBGK_S_IDLE;
          end
        end
      end
      DBGK_S_SIB_WAIT: begin
        st_d = DBGK_S_SIB_LOAD;
      end
      DBGK_S_SIB_LOAD: begin
        if (!txv_q) begin
          txv_d = 1'b1;
          txd_d = rom_data;
          txg_d = first_q; // [RL6] [RL9]
          txi_d = (!first_q && inter_byte_delay_enable_q) ? `DBGK_IDLE_BITS : 2'h0; // [RL8]
          first_d = 1'b0;
          idx_d = idx_q + 4'h1;
          cnt_d = cnt_q - 11'h001;
          st_d = (cnt_q == 11'h001) ? DBGK_S_IDLE : DBGK_S_SIB_WAIT;
        end
      end
      DBGK_S_LD_RUN: begin
        if (ldr_q && ld_valid) begin
          txv_d = 1'b1;
          txd_d = ld_data;
          txg_d = first_q; // [RL1] [RL9]
          txi_d = (!first_q && inter_byte_delay_enable_q) ? `DBGK_IDLE_BITS : 2'h0; // [RL8]
          first_d = 1'b0;
          cnt_d = cnt_q - 11'h001; // [RL20]
          if (cnt_q == 11'h001) begin
            st_d = DBGK_S_IDLE;
          end
        end
      end
      default: begin
        st_d = DBGK_S_IDLE;
      end
    endcase
    if (link_break) begin
      st_d = DBGK_S_IDLE;
    end
    // ask for the next load byte only while the output slot is free
    ldr_d = (st_d == DBGK_S_LD_RUN) && !txv_d;
  end

  // stream registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= DBGK_S_IDLE;
      cnt_q <= 11'h000;
      key_q <= 64'h0000_0000_0000_0000;
      idx_q <= 4'h0;
      first_q <= 1'b0;
      txv_q <= 1'b0;
      txd_q <= 8'h00;
      txg_q <= 1'b0;
      txi_q <= 2'h0;
      ldr_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      key_q <= key_d;
      idx_q <= idx_d;
      first_q <= first_d;
      txv_q <= txv_d;
      txd_q <= txd_d;
      txg_q <= txg_d;
      txi_q <= txi_d;
      ldr_q <= ldr_d;
    end
  end

  // bus decode: one wait state, write lands on the pready edge
  assign acc = psel && penable;
  assign widx = reg_idx(paddr);
  assign wr = acc && pready_q && pwrite && reg_ok(paddr);
  assign rel = wr && widx == `DBGK_IDX_RESET_REQUEST &&
    pwdata[7:0] == `DBGK_RESET_RELEASE && sysres_q;

  // bus answer and read data
  always_comb begin
    pready_d = acc && !pready_q;
    pslverr_d = acc && !pready_q && !reg_ok(paddr);
    prdata_d = 32'h0000_0000;
    if (acc && !pready_q && !pwrite && reg_ok(paddr)) begin
      case (widx)
        `DBGK_IDX_CTRLA: begin
          prdata_d[`DBGK_CTRLA_INTER_BYTE_DELAY_ENABLE_BIT] = inter_byte_delay_enable_q;
          prdata_d[`DBGK_CTRLA_GT_LSB +: 3] = gt_q;
        end
        `DBGK_IDX_UNLOCK_STATUS: begin
          prdata_d[`DBGK_KEY_UROW_BIT] = ku_q;
          prdata_d[`DBGK_KEY_MEM_BIT] = kn_q;
          prdata_d[`DBGK_KEY_ERASE_BIT] = ke_q; // [RL15]
        end
        `DBGK_IDX_RESET_REQUEST: begin
          prdata_d[7:0] = reset_request_code_q;
        end
        `DBGK_IDX_SYS_STATUS: begin
          prdata_d[`DBGK_SYS_LOCK_BIT] = lock_bits; // [RL17]
          prdata_d[`DBGK_SYS_UROW_BIT] = up_q;
          prdata_d[`DBGK_SYS_MEM_BIT] = mp_q;
          prdata_d[`DBGK_SYS_ERASE_FAIL_BIT] = efail_q; // [RL18]
          prdata_d[`DBGK_SYS_IN_RESET_BIT] = sysres_q;
        end
        `DBGK_IDX_BOOT_CHECKSUM: begin
          prdata_d[7:0] = boot_checksum_result; // [RL7]
        end
        default: begin
          prdata_d = 32'h0000_0000;
        end
      endcase
    end
  end

  // control, reset request, keys and status next values
  always_comb begin
    inter_byte_delay_enable_d = inter_byte_delay_enable_q;
    gt_d = gt_q;
    reset_request_code_d = reset_request_code_q;
    sysres_d = sysres_q;
    ke_d = ke_q;
    kn_d = kn_q;
    ku_d = ku_q;
    mp_d = mp_q;
    up_d = up_q;
    efail_d = efail_q;
    estart_d = rel && ke_q;
    udone_d = 1'b0;
    if (wr && widx == `DBGK_IDX_CTRLA) begin
      inter_byte_delay_enable_d = pwdata[`DBGK_CTRLA_INTER_BYTE_DELAY_ENABLE_BIT]; // [RL8]
      gt_d = pwdata[`DBGK_CTRLA_GT_LSB +: 3];
    end
    if (wr && widx == `DBGK_IDX_RESET_REQUEST) begin
      reset_request_code_d = pwdata[7:0];
      if (pwdata[7:0] == `DBGK_RESET_SIGNATURE) begin
        sysres_d = 1'b1; // [RL16]
      end else if (pwdata[7:0] == `DBGK_RESET_RELEASE) begin
        sysres_d = 1'b0; // [RL16]
      end
    end
    if (wr && widx == `DBGK_IDX_SYS_CTRLA) begin
      udone_d = pwdata[`DBGK_SYSCTRL_UROWDONE_BIT];
    end
    // invalidation first so that a key arriving now still wins
    if (port_disable) begin
      ke_d = 1'b0; // [RL13]
    end
    if (nvm_prog_done) begin
      kn_d = 1'b0; // [RL13]
      mp_d = 1'b0;
    end
    if (wr && widx == `DBGK_IDX_UNLOCK_STATUS && pwdata[`DBGK_KEY_UROW_BIT]) begin
      ku_d = 1'b0; // [RL13]
    end
    if (urow_complete) begin
      up_d = 1'b0;
    end
    if (key_done) begin
      if (key_d == `DBGK_SIG_ERASE) begin
        ke_d = 1'b1; // [RL14] [RL15]
      end
      if (key_d == `DBGK_SIG_MEM) begin
        kn_d = 1'b1; // [RL14]
      end
      if (key_d == `DBGK_SIG_UROW) begin
        ku_d = 1'b1; // [RL14]
      end
    end
    // functions open at the release of a requested reset
    if (rel && kn_q && !lock_bits) begin
      mp_d = 1'b1; // [RL13]
    end
    if (rel && ku_q && lock_bits) begin
      up_d = 1'b1; // [RL13]
    end
    if (erase_done) begin
      efail_d = erase_fail; // [RL18]
    end
  end

  // control and status registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inter_byte_delay_enable_q <= 1'(`DBGK_CTRLA_RESET >> `DBGK_CTRLA_INTER_BYTE_DELAY_ENABLE_BIT); // [RL22]
      gt_q <= 3'h0;
      reset_request_code_q <= 8'h00;
      sysres_q <= 1'b0;
      ke_q <= 1'b0; // [RL13]
      kn_q <= 1'b0;
      ku_q <= 1'b0;
      mp_q <= 1'b0;
      up_q <= 1'b0;
      efail_q <= 1'b0;
      estart_q <= 1'b0;
      udone_q <= 1'b0;
      allow_q <= 1'b0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      inter_byte_delay_enable_q <= inter_byte_delay_enable_d;
      gt_q <= gt_d;
      reset_request_code_q <= reset_request_code_d;
      sysres_q <= sysres_d;
      ke_q <= ke_d;
      kn_q <= kn_d;
      ku_q <= ku_d;
      mp_q <= mp_d;
      up_q <= up_d;
      efail_q <= efail_d;
      estart_q <= estart_d;
      udone_q <= udone_d;
      allow_q <= !lock_bits; // [RL19]
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  // outputs straight from flip-flops
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign ld_ready = ldr_q;
  assign tx_valid = txv_q;
  assign tx_data = txd_q;
  assign tx_guard = txg_q;
  assign tx_idle_bits = txi_q;
  assign guard_time = gt_q;
  assign sys_reset = sysres_q;
  assign erase_start = estart_q;
  assign nvm_prog_enable = mp_q;
  assign urow_done = udone_q;
  assign sys_bus_allow = allow_q;
endmodule : dbgk_core
`default_nettype wire

// *** src/dbgk_params.svh ***
// constants of the debug port key and information block logic
`ifndef DBGK_PARAMS_SVH
`define DBGK_PARAMS_SVH

// register indices, byte address is four times the index
`define DBGK_IDX_CTRLA 4'h2
`define DBGK_IDX_UNLOCK_STATUS 4'h7
`define DBGK_IDX_RESET_REQUEST 4'h8
`define DBGK_IDX_SYS_CTRLA 4'hA
`define DBGK_IDX_SYS_STATUS 4'hB
`define DBGK_IDX_BOOT_CHECKSUM 4'hC

// control a fields
`define DBGK_CTRLA_INTER_BYTE_DELAY_ENABLE_BIT 7
`define DBGK_CTRLA_GT_LSB 0
`define DBGK_CTRLA_RESET 8'h00

// unlock status fields
`define DBGK_KEY_UROW_BIT 5
`define DBGK_KEY_MEM_BIT 4
`define DBGK_KEY_ERASE_BIT 3

// system control a fields
`define DBGK_SYSCTRL_UROWDONE_BIT 1

// system status fields
`define DBGK_SYS_LOCK_BIT 0
`define DBGK_SYS_UROW_BIT 2
`define DBGK_SYS_MEM_BIT 3
`define DBGK_SYS_ERASE_FAIL_BIT 4
`define DBGK_SYS_IN_RESET_BIT 5

// reset request values
`define DBGK_RESET_SIGNATURE 8'hA5
`define DBGK_RESET_RELEASE 8'h00

// key signatures, least significant byte arrives first
`define DBGK_SIG_ERASE 64'h4E56_4D45_7261_7365
`define DBGK_SIG_MEM 64'h4E56_4D50_726F_6720
`define DBGK_SIG_UROW 64'h4E56_4D55_7326_7465

// stream sizes and inter-byte idle bits
`define DBGK_KEY_BYTES 5'h08
`define DBGK_SIB_BYTES 5'h10
`define DBGK_IDLE_BITS 2'h2
`define DBGK_RESERVED_BYTE 8'h00

`endif

// *** src/dbgk_pkg.sv ***
// types of the debug port key and information block logic
`default_nettype none
package dbgk_pkg;
  typedef enum logic [2:0] {
    DBGK_S_IDLE = 3'b000,
    DBGK_S_KEY_RX = 3'b001,
    DBGK_S_SIB_WAIT = 3'b010,
    DBGK_S_SIB_LOAD = 3'b011,
    DBGK_S_LD_RUN = 3'b100
  } dbgk_state_t;
endpackage : dbgk_pkg
`default_nettype wire

// *** src/dbgk_sib_rom.sv ***
// information block read-only memory with registered read data
`default_nettype none
module dbgk_sib_rom #(
  parameter int BYTES = 16,
  parameter logic [127:0] CONTENT = 128'h0
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // read port
  input wire logic [3:0] addr,
  output logic [7:0] rd_data
);
  logic [7:0] rom_w [BYTES];
  logic [7:0] rd_data_q;

  // byte n of the block sits at bits 8n+7..8n
  for (genvar i = 0; i < BYTES; i++) begin : g_byte
    assign rom_w[i] = CONTENT[i*8 +: 8];
  end

  // read data register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data_q <= 8'h00;
    end else begin
      rd_data_q <= rom_w[addr];
    end
  end

  assign rd_data = rd_data_q;
endmodule : dbgk_sib_rom
`default_nettype wire

// *** tb/dbgk_core_props.sv ***
// port timing checker of the debug port key and information block logic
`include "dbgk_params.svh"
`default_nettype none
module dbgk_core_props (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // stream and system
  input wire logic tx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_guard,
  input wire logic [1:0] tx_idle_bits,
  input wire logic ld_start,
  input wire logic ld_ready,
  input wire logic lock_bits,
  input wire logic sys_reset,
  input wire logic erase_start,
  input wire logic sys_bus_allow
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic rst_wr;
  // access phase waiting, and a completed reset request write
  assign acc = psel && penable && !pready;
  assign rst_wr = psel && penable && pready && pwrite && paddr == 12'h020;
  a_pready_one_wait: assert property (acc |=> pready)
    else $error("pready late");
  a_pready_one_pulse: assert property (pready |=> !pready)
    else $error("pready too long");
  a_slverr_unaligned: assert property (acc && paddr[1:0] != 2'b00 |=> pslverr && pready)
    else $error("unaligned not refused");
  a_bus_allow_lock: assert property ($past(presetn) |-> sys_bus_allow == !$past(lock_bits))
    else $error("bus allow wrong");
  a_load_locked_refused: assert property (ld_start && lock_bits && !ld_ready |=> !ld_ready [*2])
    else $error("load taken while locked");
  a_tx_hold_stall: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("tx byte changed in stall");
  a_guard_no_idle: assert property (tx_valid && tx_guard |-> tx_idle_bits == 2'h0)
    else $error("idle bits on guarded byte");
  a_rst_req_set: assert property (rst_wr && pwdata[7:0] == `DBGK_RESET_SIGNATURE |=> sys_reset)
    else $error("reset not raised");
  a_rst_req_hold: assert property (sys_reset && !rst_wr |=> sys_reset)
    else $error("reset dropped");
  a_erase_one_pulse: assert property (erase_start |=> !erase_start)
    else $error("erase start too long");
endmodule : dbgk_core_props
bind dbgk_core dbgk_core_props dbgk_core_props_i (.pclk, .presetn, .paddr, .psel, .penable,
  .pwrite, .pwdata, .pready, .pslverr, .tx_ready, .tx_valid, .tx_data, .tx_guard,
  .tx_idle_bits, .ld_start, .ld_ready, .lock_bits, .sys_reset, .erase_start, .sys_bus_allow);
`default_nettype wire

// *** tb/dbgk_link_model.sv ***
// far-side byte receiver model with optional random stalls
`default_nettype none
module dbgk_link_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // byte stream
  input wire logic tx_valid,
  input wire logic slow,
  output logic tx_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  // accept one cycle after tx_valid rises, or stall a random number of cycles
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      tx_ready <= 1'b0;
    else
      tx_ready <= tx_valid && (!slow || $urandom_range(3) == 0);
  end
endmodule : dbgk_link_model
`default_nettype wire

// *** tb/test_dbgk_core.sv ***
// self-checking bench of the debug port key and information block logic
`include "dbgk_params.svh"
`default_nettype none
module test_dbgk_core
  import dbgk_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // info block contents, arbitrary values
  localparam logic [127:0] BLK = 128'h3700_4431_304D_3231_0054_4553_5446_414D;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slow;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic key_start, key_sib_mode, ld_start, link_break, rx_valid, ld_valid, ld_ready;
  logic [4:0] key_frames;
  logic [2:0] ld_size, guard_time;
  logic [7:0] rpt_count, rx_data, ld_data, tx_data, boot_checksum_result;
  logic tx_ready, tx_valid, tx_guard, lock_bits, port_disable, erase_done, erase_fail;
  logic nvm_prog_done, urow_complete, sys_reset, erase_start, nvm_prog_enable, urow_done;
  logic sys_bus_allow;
  logic [1:0] tx_idle_bits;
  int err_total, num_checks, n_erase, n_udone;
  logic [33:0] exp_rd[$];
  logic [10:0] exp_tx[$];
  dbgk_core #(.FAMILY_IDENTIFIER(BLK[55:0]), .MEM_CTRL_REV(BLK[87:64]), .DEBUGGER_REV(BLK[111:88]),
    .DEBUG_OSC_FREQ(BLK[127:120])) dbgk_core_i (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .key_start, .key_sib_mode, .key_frames, .ld_start, .ld_size, .rpt_count, .link_break,
    .rx_valid, .rx_data, .ld_valid, .ld_data, .ld_ready, .tx_ready, .tx_valid, .tx_data,
    .tx_guard, .tx_idle_bits, .guard_time, .lock_bits, .port_disable, .erase_done,
    .erase_fail, .nvm_prog_done, .urow_complete, .boot_checksum_result, .sys_reset,
    .erase_start, .nvm_prog_enable, .urow_done, .sys_bus_allow);
  dbgk_link_model dbgk_link_model_i (.pclk, .presetn, .tx_valid, .slow, .tx_ready);
  // clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    num_checks++;
    if (e !== g) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  task automatic tmo(input string nm);
    err_total++;
    $display("wrong value %s expected done seen timeout", nm);
    test_done();
  endtask : tmo
  // one apb transfer; e holds read flag, pslverr and read data
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [33:0] e);
    int n;
    exp_rd.push_back(e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (!pready && n < 20);
    if (n >= 20)
      tmo("pready");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic drain();
    for (int n = 0; n < 400 && exp_tx.size() != 0; n++)
      @(posedge pclk);
    if (exp_tx.size() != 0)
      tmo("tx stream");
  endtask : drain
  task automatic kinst(input logic sib, input logic [4:0] nb);
    key_sib_mode <= sib;
    key_frames <= nb;
    key_start <= 1'b1;
    @(posedge pclk);
    key_start <= 1'b0;
  endtask : kinst
  // key bytes go least significant first, no answer expected
  task automatic key(input logic [63:0] k);
    kinst(1'b0, `DBGK_KEY_BYTES);
    for (int i = 0; i < 8; i++) begin
      rx_valid <= 1'b1;
      rx_data <= k[8*i+:8];
      @(posedge pclk);
      rx_valid <= 1'b0;
      @(posedge pclk);
    end
  endtask : key
  task automatic sib(input logic [4:0] nb, input logic ib);
    for (int i = 0; i < nb; i++)
      exp_tx.push_back({BLK[8*i+:8], i == 0, (i != 0 && ib) ? 2'h2 : 2'h0});
    kinst(1'b1, nb);
    drain();
  endtask : sib
  // repeated load, access layer bytes are random
  task automatic load(input logic [7:0] rc, input logic [2:0] sz, input logic ib);
    logic [7:0] b;
    int n;
    rpt_count <= rc;
    ld_size <= sz;
    ld_start <= 1'b1;
    @(posedge pclk);
    ld_start <= 1'b0;
    for (int i = 0; i < (rc + 1) * sz; i++) begin
      b = 8'($urandom);
      ld_data <= b;
      ld_valid <= 1'b1;
      exp_tx.push_back({b, i == 0, (i != 0 && ib) ? 2'h2 : 2'h0});
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (!ld_ready && n < 50);
      if (n >= 50)
        tmo("ld_ready");
    end
    ld_valid <= 1'b0;
    drain();
  endtask : load
  // monitor takes the oldest note for each answer and compares
  always @(posedge pclk) begin
    logic [33:0] e;
    if (pready) begin
      e = exp_rd.size() != 0 ? exp_rd.pop_front() : 34'h0;
      chk("pslverr", e[32], pslverr);
      if (e[33])
        chk("prdata", e[31:0], prdata);
    end
    if (tx_valid && tx_ready)
      chk("tx byte", exp_tx.size() != 0 ? exp_tx.pop_front() : 11'h0,
        {tx_data, tx_guard, tx_idle_bits});
    if (erase_start)
      n_erase++;
    if (urow_done)
      n_udone++;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    tmo("run");
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, key_start, key_sib_mode, key_frames} = '0;
    {ld_start, ld_size, rpt_count, link_break, rx_valid, rx_data, ld_valid, ld_data} = '0;
    {port_disable, erase_done, erase_fail, nvm_prog_done, urow_complete, slow} = '0;
    presetn = 1'b0;
    lock_bits = 1'b1;
    void'($urandom(81546));
    boot_checksum_result = 8'($urandom);
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, 12'h008, 0, {2'b10, 32'h0});
    apb(0, 12'h009, 0, {2'b11, 32'h0});
    apb(0, 12'h030, 0, {26'h200_0000, boot_checksum_result});
    ld_start <= 1'b1;
    @(posedge pclk);
    ld_start <= 1'b0;
    repeat (4) @(posedge pclk);
    chk("ld_ready locked", 0, ld_ready);
    $display("test registers done");
    sib(5'h10, 0);
    apb(1, 12'h008, 32'h0000_0083, 0);
    @(posedge pclk);
    chk("guard_time", 3, guard_time);
    slow <= 1'b1;
    sib(5'h08, 1);
    $display("test info block done");
    key(`DBGK_SIG_ERASE ^ 64'h1);
    apb(0, 12'h01C, 0, {2'b10, 32'h0});
    key(`DBGK_SIG_ERASE);
    apb(0, 12'h01C, 0, {2'b10, 32'h0000_0008});
    key(`DBGK_SIG_MEM);
    key(`DBGK_SIG_UROW);
    apb(0, 12'h01C, 0, {2'b10, 32'h0000_0038});
    apb(1, 12'h01C, 32'h0000_0020, 0);
    apb(0, 12'h01C, 0, {2'b10, 32'h0000_0018});
    $display("test keys done");
    apb(1, 12'h020, 32'h0000_00A5, 0);
    apb(0, 12'h02C, 0, {2'b10, 32'h0000_0021});
    apb(1, 12'h020, 32'h0000_0000, 0);
    repeat (2) @(posedge pclk);
    chk("erase starts", 1, n_erase);
    erase_done <= 1'b1;
    erase_fail <= 1'b1;
    @(posedge pclk);
    erase_done <= 1'b0;
    apb(0, 12'h02C, 0, {2'b10, 32'h0000_0011});
    erase_done <= 1'b1;
    erase_fail <= 1'b0;
    lock_bits <= 1'b0;
    @(posedge pclk);
    erase_done <= 1'b0;
    apb(0, 12'h02C, 0, {2'b10, 32'h0});
    chk("sys_bus_allow", 1, sys_bus_allow);
    port_disable <= 1'b1;
    @(posedge pclk);
    port_disable <= 1'b0;
    apb(0, 12'h01C, 0, {2'b10, 32'h0000_0010});
    apb(1, 12'h020, 32'h0000_00A5, 0);
    apb(1, 12'h020, 32'h0000_0000, 0);
    apb(0, 12'h02C, 0, {2'b10, 32'h0000_0008});
    chk("nvm_prog_enable", 1, nvm_prog_enable);
    apb(1, 12'h028, 32'h0000_0002, 0);
    repeat (2) @(posedge pclk);
    chk("urow_done", 1, n_udone);
    $display("test erase done");
    load(8'h02, 3'h2, 1);
    apb(1, 12'h008, 32'h0, 0);
    slow <= 1'b0;
    load(8'h00, 3'h3, 0);
    $display("test load done");
    test_done();
  end
endmodule : test_dbgk_core
`default_nettype wire
